// ==== src/srs_pkg.sv ====
// Package of constants and types for the refresh and self-refresh scheduler
package srs_pkg;
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned NUM_BANKS     = 8;
   localparam int unsigned BANK_W        = 3;
   // Times in nanoseconds
   localparam int unsigned BANK_REFRESH_CYCLE_TIME_NS    = 90;
   localparam int unsigned FULL_REFRESH_CYCLE_TIME_NS    = 130;
   localparam int unsigned MIN_SELF_REFRESH_RESIDENCY_NS = 15;
   localparam int unsigned SELF_REFRESH_EXIT_TIME_NS     = 140;
   // Least times round up, never below one cycle
   localparam int unsigned BANK_REFRESH_CYC = (BANK_REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned FULL_REFRESH_CYC = (FULL_REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned EXIT_CYC         = (SELF_REFRESH_EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Longest time for the internal refresh start: round down, at least one
   localparam int unsigned RESIDENCY_RAW    = MIN_SELF_REFRESH_RESIDENCY_NS / CLK_PERIOD_NS;
   localparam int unsigned RESIDENCY_CYC    = (RESIDENCY_RAW < 1) ? 1 : RESIDENCY_RAW;
   localparam int unsigned CNT_W            = 8;
   localparam logic [CNT_W-1:0] CNT_ZERO    = 8'h00;
   localparam logic [BANK_W-1:0] BANK_RST   = 3'h0;
   localparam logic [NUM_BANKS-1:0] BUSY_RST = 8'h00;

   typedef enum logic [2:0] {
      SRS_CMD_NOP, SRS_CMD_REF_PB, SRS_CMD_REF_AB, SRS_CMD_SELF_REFRESH, SRS_CMD_OTHER
   } srs_cmd_e;

   // Pins sampled on each rising clock edge
   typedef struct packed {
      logic       cke;
      logic       cs_n;
      logic [3:0] ca;
   } srs_pins_s;

   // Status presented to the array side
   typedef struct packed {
      logic [NUM_BANKS-1:0] bank_blocked;
      logic [BANK_W-1:0]    next_bank;
      logic                 in_self_refresh;
      logic                 exiting;
   } srs_status_s;
endpackage : srs_pkg

// ==== src/srs_bank_timer.sv ====
// Per-bank countdown that blocks a bank while it is being refreshed
`timescale 1ns/1ps
module srs_bank_timer
   import srs_pkg::*;
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Control
   input  wire logic             start,
   input  wire logic [CNT_W-1:0] load_val,
   // State
   output logic                  busy
);
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;

   always_comb begin
      nxt_cnt = cnt_ff;
      if (start) begin
         nxt_cnt = load_val;
      end else if (cnt_ff != CNT_ZERO) begin
         nxt_cnt = cnt_ff - 8'h01;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_ff <= CNT_ZERO;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   assign busy = (cnt_ff != CNT_ZERO);
endmodule : srs_bank_timer

// ==== src/srs_refresh_core.sv ====
// Device-side refresh scheduler: per-bank and all-bank refresh, self refresh
`timescale 1ns/1ps
module srs_refresh_core
   import srs_pkg::*;
#(
   parameter int unsigned SR_INTERVAL_CYC = 195
)
(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Command pins
   input  wire srs_pins_s    pins,
   // Array side
   output srs_status_s       status,
   output logic              refresh_pulse,
   output logic [BANK_W-1:0] refresh_bank,
   output logic              refresh_all
);
   typedef enum logic [1:0] {ST_ACTIVE, ST_SELF_REFRESH, ST_EXIT} srs_state_e;

   srs_state_e        state_ff,   nxt_state;
   logic [BANK_W-1:0] bank_ff,    nxt_bank;
   logic [CNT_W-1:0]  all_cnt_ff, nxt_all_cnt;
   logic [CNT_W-1:0]  sr_cnt_ff,  nxt_sr_cnt;
   logic [CNT_W-1:0]  exit_cnt_ff, nxt_exit_cnt;
   logic              pulse_ff,   nxt_pulse;
   logic [BANK_W-1:0] rbank_ff,   nxt_rbank;
   logic              rall_ff,    nxt_rall;
   logic              cke_prev_ff, nxt_cke_prev;
   logic              start_ref;
   logic              start_all;
   srs_cmd_e          cmd;
   logic [NUM_BANKS-1:0] pb_start;
   logic [NUM_BANKS-1:0] pb_busy;

   function automatic srs_cmd_e decode(input srs_pins_s p, input logic cke_prev);
      srs_cmd_e c;
      c = SRS_CMD_OTHER;
      if (p.cs_n) begin
         c = SRS_CMD_NOP;
      end else if (p.ca[2:0] == 3'h4) begin
         if (cke_prev && !p.cke) begin
            c = SRS_CMD_SELF_REFRESH;
         end else if (p.cke) begin
            c = p.ca[3] ? SRS_CMD_REF_AB : SRS_CMD_REF_PB;
         end
      end
      return c;
   endfunction : decode

   // Saturating step down shared by the full-refresh, self-refresh and exit countdowns; bank timers count on their own
   function automatic logic [CNT_W-1:0] count_down(input logic [CNT_W-1:0] v);
      logic [CNT_W-1:0] r;
      r = v;
      if (v != CNT_ZERO) begin
         r = v - 8'h01;
      end
      return r;
   endfunction : count_down

   assign cmd = decode(pins, cke_prev_ff);

   genvar g;
   generate
      for (g = 0; g < NUM_BANKS; g++) begin : g_bank
         srs_bank_timer u_timer (
            .clk      (clk),
            .rst      (rst),
            .start    (pb_start[g]),
            .load_val (CNT_W'(BANK_REFRESH_CYC)),
            .busy     (pb_busy[g])
         );
      end
   endgenerate

   always_comb begin
      nxt_state    = state_ff;
      nxt_bank     = bank_ff;
      nxt_all_cnt  = count_down(all_cnt_ff);
      nxt_sr_cnt   = sr_cnt_ff;
      nxt_exit_cnt = exit_cnt_ff;
      start_ref    = 1'b0;
      start_all    = 1'b0;
      pb_start     = '0;
      unique case (state_ff)
         ST_ACTIVE: begin
            if (cmd == SRS_CMD_REF_PB) begin
               pb_start[bank_ff] = 1'b1;
               nxt_bank  = bank_ff + 3'h1;
               start_ref = 1'b1;
            end else if (cmd == SRS_CMD_REF_AB) begin
               nxt_bank    = BANK_RST;
               nxt_all_cnt = CNT_W'(FULL_REFRESH_CYC);
               start_ref   = 1'b1;
               start_all   = 1'b1;
            end else if (cmd == SRS_CMD_SELF_REFRESH) begin
               nxt_state  = ST_SELF_REFRESH;
               nxt_sr_cnt = CNT_W'(RESIDENCY_CYC);
            end
         end
         ST_SELF_REFRESH: begin
            // Only CKE is looked at here; an internal timer drives refreshes
            if (sr_cnt_ff == 8'h01) begin
               start_ref   = 1'b1;
               start_all   = 1'b1;
               nxt_all_cnt = CNT_W'(FULL_REFRESH_CYC);
               nxt_sr_cnt  = CNT_W'(SR_INTERVAL_CYC);
            end else begin
               nxt_sr_cnt = count_down(sr_cnt_ff);
            end
            if (pins.cke) begin
               nxt_state    = ST_EXIT;
               nxt_bank     = BANK_RST;
               nxt_exit_cnt = CNT_W'(EXIT_CYC);
            end
         end
         ST_EXIT: begin
            // Lets an internal refresh in progress finish before commands count
            nxt_exit_cnt = count_down(exit_cnt_ff);
            if (exit_cnt_ff == 8'h01) begin
               nxt_state = ST_ACTIVE;
            end
         end
         default: begin
            // Unused state code: recover to command decoding with the bank counter cleared
            nxt_state    = ST_ACTIVE;
            nxt_bank     = BANK_RST;
            nxt_exit_cnt = CNT_ZERO;
         end
      endcase
   end

   // Report of the last refresh started; the bank only moves for single-bank refreshes
   always_comb begin
      nxt_pulse = start_ref;
      nxt_rbank = rbank_ff;
      nxt_rall  = rall_ff;
      if (start_ref) begin
         nxt_rall = start_all;
         if (!start_all) begin
            nxt_rbank = bank_ff;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff    <= ST_ACTIVE;
         bank_ff     <= BANK_RST;
         all_cnt_ff  <= CNT_ZERO;
         sr_cnt_ff   <= CNT_ZERO;
         exit_cnt_ff <= CNT_ZERO;
      end else begin
         state_ff    <= nxt_state;
         bank_ff     <= nxt_bank;
         all_cnt_ff  <= nxt_all_cnt;
         sr_cnt_ff   <= nxt_sr_cnt;
         exit_cnt_ff <= nxt_exit_cnt;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pulse_ff <= 1'b0;
         rbank_ff <= BANK_RST;
         rall_ff  <= 1'b0;
      end else begin
         pulse_ff <= nxt_pulse;
         rbank_ff <= nxt_rbank;
         rall_ff  <= nxt_rall;
      end
   end

   // CKE history for entry decode; cleared in reset, so the first entry needs a CKE-high edge before it
   always_comb begin
      nxt_cke_prev = pins.cke;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cke_prev_ff <= 1'b0;
      end else begin
         cke_prev_ff <= nxt_cke_prev;
      end
   end

   // Blocked bits drop on their own when the countdown ends, leaving banks idle
   assign status.bank_blocked    = pb_busy | {NUM_BANKS{all_cnt_ff != CNT_ZERO}};
   assign status.next_bank       = bank_ff;
   assign status.in_self_refresh = (state_ff == ST_SELF_REFRESH);
   assign status.exiting         = (state_ff == ST_EXIT);
   assign refresh_pulse          = pulse_ff;
   assign refresh_bank           = rbank_ff;
   assign refresh_all            = rall_ff;
endmodule : srs_refresh_core

// ==== tb/srs_checker.sv ====
// Port assertions for the refresh scheduler
`timescale 1ns/1ps
module srs_checker
   import srs_pkg::*;
#(
   parameter int unsigned SR_INTERVAL_CYC = 195
)
(
   // Watched ports
   input wire logic              clk,
   input wire logic              rst,
   input wire srs_pins_s         pins,
   input wire srs_status_s       status,
   input wire logic              refresh_pulse,
   input wire logic [BANK_W-1:0] refresh_bank,
   input wire logic              refresh_all
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire act  = !status.in_self_refresh && !status.exiting;
   wire cmd  = !pins.cs_n && pins.ca[2:0] == 3'h4;
   wire pb_c = act && pins.cke && cmd && !pins.ca[3];
   wire ab_c = act && pins.cke && cmd && pins.ca[3];
   sequence s_pb_hold;
      (status.bank_blocked == 8'h01 << refresh_bank) [*3] ##1 status.bank_blocked == 8'h00;
   endsequence
   sequence s_ab_hold;
      (status.bank_blocked == 8'hFF) [*4] ##1 status.bank_blocked == 8'h00;
   endsequence
   a_pb_window: assert property (
      pb_c |=> refresh_pulse && !refresh_all && refresh_bank == $past(status.next_bank) ##0 s_pb_hold) else $error("bank refresh");
   a_bank_step: assert property (
      pb_c |=> status.next_bank == $past(status.next_bank) + 3'h1) else $error("bank step");
   a_ab_window: assert property (
      ab_c |=> refresh_pulse && refresh_all && status.next_bank == 3'h0 ##0 s_ab_hold) else $error("full refresh");
   a_sr_enter: assert property (
      act && cmd && !pins.cke && $past(pins.cke) |=> status.in_self_refresh) else $error("sr entry");
   a_sr_internal: assert property (
      $rose(status.in_self_refresh) |-> ##[0:2] refresh_pulse && refresh_all) else $error("sr refresh");
   a_sr_ignore: assert property (
      status.in_self_refresh && !pins.cke |=> status.in_self_refresh && !(refresh_pulse && !refresh_all)) else $error("sr ignore");
   a_exit_start: assert property (
      status.in_self_refresh && pins.cke |=> status.exiting && status.next_bank == 3'h0) else $error("exit start");
   a_exit_len: assert property (
      $rose(status.exiting) |-> (status.exiting && status.next_bank == 3'h0) [*4] ##1 !status.exiting) else $error("exit length");
   a_sr_period: assert property (
      status.in_self_refresh && refresh_pulse && refresh_all
      |-> ##SR_INTERVAL_CYC (!status.in_self_refresh || refresh_pulse)) else $error("sr period");
endmodule : srs_checker
bind srs_refresh_core srs_checker #(.SR_INTERVAL_CYC(SR_INTERVAL_CYC)) u_chk (.clk(clk), .rst(rst), .pins(pins),
   .status(status), .refresh_pulse(refresh_pulse), .refresh_bank(refresh_bank), .refresh_all(refresh_all));

// ==== tb/srs_ctrl_model.sv ====
// Memory controller model driving the command pins
`timescale 1ns/1ps
module srs_ctrl_model
   import srs_pkg::*;
(
   // Clock and command pins
   input  wire logic clk,
   output srs_pins_s pins
);
   int seed = 37;
   initial pins = '{1'h0, 1'h1, 4'h0};
   task automatic drive(input logic cke, input logic cs_n, input logic [3:0] ca);
      @(posedge clk);
      #1;
      pins = '{cke, cs_n, ca};
   endtask : drive
   // Deselect with a moving pattern; in self refresh all but CKE is random
   task automatic idle(input int n, input logic cke);
      repeat (n) drive(cke, cke | 1'($random(seed)), 4'($random(seed)));
   endtask : idle
   task automatic sr_enter();
      drive(1'h0, 1'h0, 4'h4);
      drive(1'h0, 1'h0, 4'hF);
   endtask : sr_enter
endmodule : srs_ctrl_model

// ==== tb/tb_top.sv ====
// Self-checking bench for the refresh scheduler
`timescale 1ns/1ps
module tb_top;
   import srs_pkg::*;
   logic              clk = 1'h0;
   logic              rst = 1'h1;
   srs_pins_s         pins;
   srs_status_s       status;
   logic              pulse;
   logic [BANK_W-1:0] rbank;
   logic              rall;
   int                fails = 0;
   int                cmp_count = 0;
   int                nb = 0;
   int                sr_refs = 0;
   initial forever #20 clk = ~clk;
   srs_ctrl_model ctl (.clk(clk), .pins(pins));
   // Short internal period keeps self refresh runs brief
   srs_refresh_core #(.SR_INTERVAL_CYC(6)) dut (.clk(clk), .rst(rst), .pins(pins), .status(status),
      .refresh_pulse(pulse), .refresh_bank(rbank), .refresh_all(rall));
   always @(posedge clk) if (status.in_self_refresh && pulse && rall) sr_refs++;
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s exp %h got %h", what, exp, got);
      end
   endtask : chk
   task automatic give_verdict();
      if (fails == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : give_verdict
   task automatic do_ref(input logic all);
      logic [2:0] b;
      b = 3'(nb);
      ctl.drive(1'h1, 1'h0, {all, 3'h4});
      ctl.idle(1, 1'h1);
      nb = all ? 0 : (nb + 1) % NUM_BANKS;
      chk("pulse", 8'h01, 8'(pulse));
      chk("all", 8'(all), 8'(rall));
      chk("next", 8'(nb), 8'(status.next_bank));
      chk("blk", all ? 8'hFF : 8'h01 << b, status.bank_blocked);
      if (!all)
         chk("bank", 8'(b), 8'(rbank));
      ctl.idle(4, 1'h1);
      chk("idle", 8'h00, status.bank_blocked);
      chk("pulse_end", 8'h00, 8'(pulse));
      // All-bank refreshes four full cycles apart, so a burst window never holds more than eight
      if (all)
         ctl.idle(int'(4 * FULL_REFRESH_CYC) - 6, 1'h1);
   endtask : do_ref
   initial begin
      repeat (6) @(posedge clk);
      #1;
      rst = 1'h0;
      ctl.idle(2, 1'h1);
      repeat (10) do_ref(1'h0);
      do_ref(1'h1);
      repeat (12) do_ref(1'($random(ctl.seed)));
      for (int k = 0; k < 2; k++) begin
         do_ref(1'h0);
         sr_refs = 0;
         ctl.sr_enter();
         ctl.idle(20, 1'h0);
         chk("in_sr", 8'h01, 8'(status.in_self_refresh));
         chk("sr_refs", 8'h01, 8'(sr_refs >= 3));
         ctl.drive(1'h1, 1'h0, 4'hF);
         ctl.drive(1'h1, 1'h0, 4'hF);
         chk("exiting", 8'h01, 8'(status.exiting));
         repeat (EXIT_CYC) ctl.drive(1'h1, 1'h0, 4'hF);
         chk("exited", 8'h00, 8'(status.exiting));
         nb = 0;
         repeat (8) do_ref(1'h0);
      end
      give_verdict();
   end
   initial begin
      #100000;
      fails++;
      give_verdict();
   end
endmodule : tb_top
